// File: hw/aesu_extract.sv
// Purpose: accumulator extract unit, decode, execute and control flag upkeep
// Assumes: pipeline holds accumulators and supplies operands with the instruction
// Notes: one-cycle latency; results and exceptions registered
`timescale 1ns/1ps
`default_nettype none
module aesu_extract
    import aesu_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic issue_valid,
    input wire logic [31:0] issue_instr,
    input wire logic [31:0] shift_source_reg,
    input wire logic [AESU_NUM_ACC-1:0][31:0] acc_high_word,
    input wire logic [AESU_NUM_ACC-1:0][31:0] acc_low_word,
    input wire logic dsp_implemented,
    input wire logic dsp_enabled,
    input wire logic ctrl_wr_en,
    input wire logic [31:0] ctrl_wr_mask,
    input wire logic [31:0] ctrl_wr_data,
    output logic issue_accepted,
    output logic result_valid,
    output logic [31:0] result_word,
    output logic [4:0] destination_reg,
    output logic ovf_event,
    output logic exc_reserved_instr,
    output logic exc_dsp_disabled,
    output logic [31:0] dsp_control_reg
);
    typedef struct packed {
        logic valid;
        logic [31:0] word;
        logic [4:0] dst;
        logic ovf;
        logic exc_ri;
        logic exc_dd;
        logic [31:0] ctrl;
    } aesu_state_s;

    aesu_state_s st_q;
    aesu_state_s st_d;

    aesu_op_e op;
    logic [4:0] sub_op;
    logic [1:0] accumulator_select;
    logic [AESU_SHAMT_W-1:0] shamt;
    logic [31:0] sel_high;
    logic [31:0] sel_low;
    logic [64:0] word_temp;
    logic [63:0] half_temp;
    logic [31:0] sat_result;
    logic sat_ovf;
    logic execute;

    assign op = aesu_decode(issue_instr); // [RULE13] [RULE14] [RULE15]
    assign sub_op = issue_instr[AESU_SUB_MSB:AESU_SUB_LSB];
    assign accumulator_select = issue_instr[AESU_ACC_MSB:AESU_ACC_LSB];

    // immediate count or low five bits of the source register, upper bits dropped
    assign shamt = aesu_is_var(sub_op) ?
                   shift_source_reg[AESU_SHAMT_W-1:0] : // [RULE2] [RULE12]
                   issue_instr[AESU_SRC_MSB:AESU_SRC_LSB];

    // read-only view of the accumulators; nothing here can write them
    assign sel_high = acc_high_word[accumulator_select]; // [RULE10] [RULE11]
    assign sel_low = acc_low_word[accumulator_select]; // [RULE10]

    assign issue_accepted = issue_valid && (op != AESU_OP_NONE);
    assign execute = issue_accepted && dsp_implemented && dsp_enabled;

    aesu_shift u_shift (
        .acc_high_word(sel_high),
        .acc_low_word(sel_low),
        .shamt(shamt),
        .word_temp(word_temp),
        .half_temp(half_temp)
    );

    aesu_sat u_sat (
        .op(op),
        .word_temp(word_temp),
        .half_temp(half_temp),
        .result(sat_result),
        .ovf(sat_ovf)
    );

    always_comb begin
        st_d = st_q;
        st_d.valid = execute;
        st_d.ovf = execute && sat_ovf;
        // exceptions depend only on availability, never on operand values
        st_d.exc_ri = issue_accepted && !dsp_implemented; // [RULE17] [RULE16]
        st_d.exc_dd = issue_accepted && dsp_implemented && !dsp_enabled; // [RULE17]
        if (execute) begin
            st_d.word = sat_result;
            st_d.dst = issue_instr[AESU_DST_MSB:AESU_DST_LSB];
        end
        if (ctrl_wr_en) begin
            st_d.ctrl = (st_q.ctrl & ~ctrl_wr_mask) | (ctrl_wr_data & ctrl_wr_mask);
        end
        // flag set beats a software clear landing in the same cycle
        if (execute && sat_ovf) begin
            st_d.ctrl[AESU_OUFLAG_BIT] = 1'b1; // [RULE3] [RULE8]
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '{valid: 1'b0, word: '0, dst: '0, ovf: 1'b0,
                      exc_ri: 1'b0, exc_dd: 1'b0, ctrl: AESU_CTRL_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign result_valid = st_q.valid;
    assign result_word = st_q.word;
    assign destination_reg = st_q.dst;
    assign ovf_event = st_q.ovf;
    assign exc_reserved_instr = st_q.exc_ri;
    assign exc_dsp_disabled = st_q.exc_dd;
    assign dsp_control_reg = st_q.ctrl;
endmodule // aesu_extract
`default_nettype wire

// File: hw/aesu_pkg.sv
// Purpose: shared constants, types and helpers for the accumulator extract unit
// Assumes: 32-bit instruction words, four 64-bit accumulators held outside this block
// Notes: field positions follow the extract instruction layout
//
// Operation
// [RULE1] halfword saturation clamps to 0x00007fff or 0xffff8000
// [RULE2] variable halfword shift uses low five bits
// [RULE3] halfword saturation sets control bit 23
// [RULE4] accumulator shifted right arithmetically, sign replicated
// [RULE5] plain word: low 32 shifted bits
// [RULE6] rounding word: add one at top discarded bit
// [RULE7] round-saturate word clamps to 0x7fffffff or 0x80000000
// [RULE8] word overflow of either intermediate sets bit 23
// [RULE9] 65-bit intermediate, result is bits 32..1
// [RULE10] two-bit select picks accumulator 0 to 3
// [RULE11] accumulators never written, only result and flag
// [RULE12] variable word shift uses low five bits
// [RULE13] immediate word extracts decoded by sub-op 00000/00100/00110
// [RULE14] register word extracts decoded by sub-op 00001/00101/00111
// [RULE15] register halfword extract: sub-op 01111, bits 15..13 zero
// [RULE16] no value-dependent exceptions, overflow only via flag
// [RULE17] reserved-instruction or dsp-disabled exception when unavailable
// [RULE18] issuer supplies well-formed operands, else result undefined
package aesu_pkg;

    localparam int AESU_MAJ_MSB = 31;
    localparam int AESU_MAJ_LSB = 26;
    localparam int AESU_SRC_MSB = 25;
    localparam int AESU_SRC_LSB = 21;
    localparam int AESU_DST_MSB = 20;
    localparam int AESU_DST_LSB = 16;
    localparam int AESU_ZRO_MSB = 15;
    localparam int AESU_ZRO_LSB = 13;
    localparam int AESU_ACC_MSB = 12;
    localparam int AESU_ACC_LSB = 11;
    localparam int AESU_SUB_MSB = 10;
    localparam int AESU_SUB_LSB = 6;
    localparam int AESU_FN_MSB = 5;
    localparam int AESU_FN_LSB = 0;
    localparam int AESU_SHAMT_W = 5;
    localparam int AESU_NUM_ACC = 4;
    localparam int AESU_OUFLAG_BIT = 23;

    localparam logic [5:0] AESU_MAJOR_OPCODE_CLASS = 6'h1f;
    localparam logic [5:0] AESU_FUNC_EXTRACT = 6'h38;
    localparam logic [2:0] AESU_ZERO_FIELD = 3'h0;

    localparam logic [4:0] AESU_SUB_W = 5'h00;
    localparam logic [4:0] AESU_SUB_WR = 5'h04;
    localparam logic [4:0] AESU_SUB_WRS = 5'h06;
    localparam logic [4:0] AESU_SUB_VW = 5'h01;
    localparam logic [4:0] AESU_SUB_VWR = 5'h05;
    localparam logic [4:0] AESU_SUB_VWRS = 5'h07;
    localparam logic [4:0] AESU_SUB_HS = 5'h0e;
    localparam logic [4:0] AESU_SUB_VHS = 5'h0f;

    localparam logic [31:0] AESU_HALF_MAX = 32'h00007fff;
    localparam logic [31:0] AESU_HALF_MIN = 32'hffff8000;
    localparam logic [31:0] AESU_WORD_MAX = 32'h7fffffff;
    localparam logic [31:0] AESU_WORD_MIN = 32'h80000000;
    localparam logic [63:0] AESU_HALF_MAX64 = 64'h0000000000007fff;
    localparam logic [63:0] AESU_HALF_MIN64 = 64'hffffffffffff8000;
    localparam logic [31:0] AESU_CTRL_RESET = 32'h00000000;
    localparam logic [64:0] AESU_ROUND_ONE = 65'h00000000000000001;

    typedef enum logic [2:0] {
        AESU_OP_NONE = 3'h0,
        AESU_OP_W = 3'h1,
        AESU_OP_WR = 3'h3,
        AESU_OP_WRS = 3'h2,
        AESU_OP_H = 3'h6
    } aesu_op_e;

    // upper bits neither all zero nor all one means outside signed 32-bit range
    function automatic logic aesu_word_ovf(input logic [64:0] t);
        return !((t[64:32] == '0) || (t[64:32] == '1));
    endfunction

    function automatic aesu_op_e aesu_decode(input logic [31:0] ins);
        aesu_op_e op;
        op = AESU_OP_NONE;
        if (ins[AESU_MAJ_MSB:AESU_MAJ_LSB] == AESU_MAJOR_OPCODE_CLASS &&
            ins[AESU_FN_MSB:AESU_FN_LSB] == AESU_FUNC_EXTRACT &&
            ins[AESU_ZRO_MSB:AESU_ZRO_LSB] == AESU_ZERO_FIELD) begin
            case (ins[AESU_SUB_MSB:AESU_SUB_LSB])
                AESU_SUB_W, AESU_SUB_VW: op = AESU_OP_W;
                AESU_SUB_WR, AESU_SUB_VWR: op = AESU_OP_WR;
                AESU_SUB_WRS, AESU_SUB_VWRS: op = AESU_OP_WRS;
                AESU_SUB_HS, AESU_SUB_VHS: op = AESU_OP_H;
                default: op = AESU_OP_NONE;
            endcase
        end
        return op;
    endfunction

    // the four odd extract sub-op codes take the count from the shift source register
    function automatic logic aesu_is_var(input logic [4:0] sub);
        return (sub == AESU_SUB_VW) || (sub == AESU_SUB_VWR) ||
               (sub == AESU_SUB_VWRS) || (sub == AESU_SUB_VHS);
    endfunction

endpackage

// File: hw/aesu_shift.sv
// Purpose: arithmetic right shift of a 64-bit accumulator
// Assumes: shift count already reduced to five bits
// Notes: purely combinational, caller registers the result
`timescale 1ns/1ps
`default_nettype none
module aesu_shift
    import aesu_pkg::*;
(
    input wire logic [31:0] acc_high_word,
    input wire logic [31:0] acc_low_word,
    input wire logic [AESU_SHAMT_W-1:0] shamt,
    output logic [64:0] word_temp,
    output logic [63:0] half_temp
);
    logic signed [64:0] ext_word;
    logic signed [63:0] ext_half;

    // one guard bit below keeps the top discarded bit; zero shift gives a zero guard
    assign ext_word = {acc_high_word, acc_low_word, 1'b0}; // [RULE9]
    assign ext_half = {acc_high_word, acc_low_word};
    assign word_temp = ext_word >>> shamt; // [RULE4]
    assign half_temp = ext_half >>> shamt; // [RULE4]
endmodule // aesu_shift
`default_nettype wire

// File: hw/aesu_sat.sv
// Purpose: rounding and saturation of shifted accumulator values
// Assumes: inputs come from aesu_shift
// Notes: combinational; overflow flag covers both word intermediates
`timescale 1ns/1ps
`default_nettype none
module aesu_sat
    import aesu_pkg::*;
(
    input wire aesu_op_e op,
    input wire logic [64:0] word_temp,
    input wire logic [63:0] half_temp,
    output logic [31:0] result,
    output logic ovf
);
    logic [64:0] rounded;
    logic raw_ovf;
    logic rnd_ovf;

    assign rounded = word_temp + AESU_ROUND_ONE; // [RULE6]
    assign raw_ovf = aesu_word_ovf(word_temp);
    assign rnd_ovf = aesu_word_ovf(rounded);

    always_comb begin
        result = word_temp[32:1];
        ovf = 1'b0;
        case (op)
            AESU_OP_W: begin
                result = word_temp[32:1]; // [RULE5]
                ovf = raw_ovf | rnd_ovf; // [RULE8]
            end
            AESU_OP_WR: begin
                result = rounded[32:1]; // [RULE6]
                ovf = raw_ovf | rnd_ovf; // [RULE8]
            end
            AESU_OP_WRS: begin
                result = rounded[32:1];
                if (rnd_ovf) begin
                    result = rounded[64] ? AESU_WORD_MIN : AESU_WORD_MAX; // [RULE7]
                end
                ovf = raw_ovf | rnd_ovf; // [RULE8]
            end
            AESU_OP_H: begin
                result = half_temp[31:0];
                if ($signed(half_temp) > $signed(AESU_HALF_MAX64)) begin
                    result = AESU_HALF_MAX; // [RULE1]
                    ovf = 1'b1; // [RULE3]
                end else if ($signed(half_temp) < $signed(AESU_HALF_MIN64)) begin
                    result = AESU_HALF_MIN; // [RULE1]
                    ovf = 1'b1; // [RULE3]
                end
            end
            default: begin
                result = word_temp[32:1];
                ovf = 1'b0;
            end
        endcase
    end
endmodule // aesu_sat
`default_nettype wire

// File: bench/aesu_extract_asserts.sv
// Purpose: port checks for aesu_extract
// Assumes: single clock, sync reset
// Notes: data values judged in bench
`timescale 1ns/1ps
`default_nettype none
module aesu_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic issue_accepted,
    input wire logic dsp_implemented,
    input wire logic dsp_enabled,
    input wire logic ctrl_wr_en,
    input wire logic result_valid,
    input wire logic ovf_event,
    input wire logic exc_reserved_instr,
    input wire logic exc_dsp_disabled,
    input wire logic [31:0] dsp_control_reg
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_run;
        issue_accepted && dsp_implemented && dsp_enabled;
    endsequence
    sequence s_quiet;
        !result_valid && !ovf_event;
    endsequence
    AST_RUN: assert property (s_run |=> result_valid)
        else $error("no result after extract");
    AST_RSVD: assert property (issue_accepted && !dsp_implemented
        |=> exc_reserved_instr ##0 s_quiet) else $error("no reserved exception");
    AST_DIS: assert property (issue_accepted && dsp_implemented && !dsp_enabled
        |=> exc_dsp_disabled ##0 s_quiet) else $error("no disabled exception");
    AST_IDLE: assert property (!issue_accepted
        |=> s_quiet ##0 (!exc_reserved_instr && !exc_dsp_disabled)) else $error("stray pulse");
    AST_FLAG: assert property (ovf_event |-> dsp_control_reg[23])
        else $error("overflow without flag");
    AST_STICK: assert property (dsp_control_reg[23] && !ctrl_wr_en |=> dsp_control_reg[23])
        else $error("flag lost");
    AST_NOOVF: assert property (ovf_event |-> result_valid)
        else $error("overflow without result");
    AST_NOEXC: assert property (result_valid |-> !exc_reserved_instr && !exc_dsp_disabled)
        else $error("exception with result");
endmodule // aesu_chk
bind aesu_extract aesu_chk u_chk (.clk(clk), .sys_rst(sys_rst), .issue_accepted(issue_accepted),
    .dsp_implemented(dsp_implemented), .dsp_enabled(dsp_enabled), .ctrl_wr_en(ctrl_wr_en),
    .result_valid(result_valid), .ovf_event(ovf_event),
    .exc_reserved_instr(exc_reserved_instr), .exc_dsp_disabled(exc_dsp_disabled),
    .dsp_control_reg(dsp_control_reg));
`default_nettype wire

// File: bench/aesu_pipe_model.sv
// Purpose: pipeline side holding the four accumulators
// Assumes: bench loads one accumulator per write
// Notes: extract unit only reads them
`timescale 1ns/1ps
`default_nettype none
module aesu_pipe_model
    import aesu_pkg::*;
(
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire logic [63:0] wr_val,
    output logic [AESU_NUM_ACC-1:0][31:0] acc_high_word,
    output logic [AESU_NUM_ACC-1:0][31:0] acc_low_word
);
    // sole writer, so an extract can never alter them
    always_ff @(posedge clk) begin
        if (wr_en) begin
            acc_high_word[wr_sel] <= wr_val[63:32];
            acc_low_word[wr_sel] <= wr_val[31:0];
        end
    end
endmodule // aesu_pipe_model
`default_nettype wire

// File: bench/testbench.sv
// Purpose: self-checking bench for aesu_extract
// Assumes: one-cycle answer, fixed waits
// Notes: expectations from own reference
`timescale 1ns/1ps
`default_nettype none
module testbench
    import aesu_pkg::*;
;
    logic clk = 1'b0, sys_rst = 1'b1, iv = 1'b0, impl = 1'b1, en = 1'b1;
    logic cwe = 1'b0, wr_en = 1'b0, acc_ok, rv, ov, eri, edd;
    logic [31:0] instr = '0, src = '0, cmask = '0, cdata = '0, rw, ctl;
    logic [1:0] wr_sel = '0;
    logic [63:0] wr_val = '0;
    logic [AESU_NUM_ACC-1:0][31:0] ahi, alo;
    logic [4:0] dr;
    int n_fail = 0, total_checks = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    aesu_pipe_model u_pipe (.clk(clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_val(wr_val),
        .acc_high_word(ahi), .acc_low_word(alo));
    aesu_extract DUT (.clk(clk), .sys_rst(sys_rst), .issue_valid(iv), .issue_instr(instr),
        .shift_source_reg(src), .acc_high_word(ahi), .acc_low_word(alo),
        .dsp_implemented(impl), .dsp_enabled(en), .ctrl_wr_en(cwe), .ctrl_wr_mask(cmask),
        .ctrl_wr_data(cdata), .issue_accepted(acc_ok), .result_valid(rv), .result_word(rw),
        .destination_reg(dr), .ovf_event(ov), .exc_reserved_instr(eri),
        .exc_dsp_disabled(edd), .dsp_control_reg(ctl));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // returns {overflow, word}
    function automatic logic [32:0] ref_op(logic [4:0] sub, logic [63:0] a, logic [4:0] sh);
        logic signed [64:0] t, r;
        logic signed [63:0] h;
        logic ot, orr;
        t = $signed({a, 1'b0}) >>> sh;
        r = t + 65'sh1;
        ot = t[64:32] != '0 && t[64:32] != '1;
        orr = r[64:32] != '0 && r[64:32] != '1;
        h = $signed(a) >>> sh;
        if (sub[3] && h > 64'sh7fff) return {1'b1, AESU_HALF_MAX};
        if (sub[3] && h < -64'sh8000) return {1'b1, AESU_HALF_MIN};
        if (sub[3]) return {1'b0, h[31:0]};
        if (!sub[2]) return {ot | orr, t[32:1]};
        if (sub[1] && orr) return {1'b1, r[64] ? AESU_WORD_MIN : AESU_WORD_MAX};
        return {ot | orr, r[32:1]};
    endfunction
    task automatic issue(input logic [31:0] w, input logic [31:0] s, input logic ea,
        input logic im, input logic e);
        @(posedge clk);
        wr_en <= 1'b0;
        impl <= im;
        en <= e;
        iv <= 1'b1;
        instr <= w;
        src <= s;
        #1;
        chk("accepted", 32'(ea), 32'(acc_ok));
        @(posedge clk);
        iv <= 1'b0;
        #1;
    endtask
    task automatic run(input logic [4:0] sub, input logic [1:0] sel, input logic [63:0] a,
        input logic [31:0] s);
        logic [32:0] e;
        logic [4:0] fld;
        e = ref_op(sub, a, s[4:0]);
        fld = sub[0] ? ~s[4:0] : s[4:0];
        @(posedge clk);
        wr_en <= 1'b1;
        wr_sel <= sel;
        wr_val <= a;
        issue({AESU_MAJOR_OPCODE_CLASS, fld, sel, sub[2:0], AESU_ZERO_FIELD, sel, sub,
            AESU_FUNC_EXTRACT}, s, 1'b1, 1'b1, 1'b1);
        chk("valid", 32'h1, 32'(rv));
        chk("result", e[31:0], rw);
        chk("overflow", 32'(e[32]), 32'(ov));
        chk("dest", 32'({sel, sub[2:0]}), 32'(dr));
        if (e[32]) chk("flag", 32'h1, 32'(ctl[23]));
    endtask
    task automatic sc_words();
        logic [63:0] av [4] = '{64'h0000_0000_7fff_ffff, 64'h0000_0000_ffff_ffff,
            64'hffff_ffff_0000_0000, 64'h8000_0000_0000_0000};
        logic [31:0] sv [4] = '{32'h0, 32'h1, 32'hffff_ffe1, 32'hffff_ffff};
        logic [4:0] ops [6] = '{5'h00, 5'h04, 5'h06, 5'h01, 5'h05, 5'h07};
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 6; j++) begin
                run(ops[j], i[1:0], av[i], sv[i]);
            end
        end
    endtask
    task automatic sc_half();
        logic [63:0] av [4] = '{64'h0000_0000_0000_7fff, 64'h0000_0000_0001_0000,
            64'hffff_ffff_ffff_0000, 64'hffff_ffff_fffe_0000};
        logic [31:0] sv [4] = '{32'h0, 32'h1, 32'hffff_ffe1, 32'h1};
        for (int i = 0; i < 4; i++) begin
            run(5'h0e, i[1:0], av[i], sv[i]);
            run(5'h0f, i[1:0], av[i], sv[i]);
        end
    endtask
    task automatic sc_ctrl();
        run(5'h0e, 2'h1, 64'h0000_0000_0001_0000, 32'h1);
        @(posedge clk);
        cwe <= 1'b1;
        cmask <= 32'h0080_00ff;
        cdata <= 32'h0000_0055;
        @(posedge clk);
        cwe <= 1'b0;
        #1;
        chk("ctrl", 32'h0000_0055, ctl);
        run(5'h0e, 2'h2, 64'h0000_0000_0000_1234, 32'h0);
        chk("flag", 32'h0, 32'(ctl[23]));
        // saturating extract meets a clearing write in one cycle; the set must win
        @(posedge clk);
        cwe <= 1'b1;
        cmask <= 32'h0080_0000;
        cdata <= 32'h0;
        iv <= 1'b1;
        instr <= {AESU_MAJOR_OPCODE_CLASS, 5'h01, 5'h00, AESU_ZERO_FIELD, 2'h1, AESU_SUB_HS,
            AESU_FUNC_EXTRACT};
        @(posedge clk);
        cwe <= 1'b0;
        iv <= 1'b0;
        #1;
        chk("flag set wins", 32'h1, 32'(ctl[23]));
    endtask
    task automatic sc_reset();
        run(5'h0f, 2'h3, 64'hffff_ffff_fffe_0000, 32'h1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        chk("reset ctrl", AESU_CTRL_RESET, ctl);
        chk("reset result", 32'h0, rw);
        chk("reset pulses", 32'h0, 32'({rv, ov, eri, edd, dr}));
    endtask
    task automatic sc_exc();
        logic [31:0] w;
        w = {AESU_MAJOR_OPCODE_CLASS, 10'h0, AESU_ZERO_FIELD, 2'h0, AESU_SUB_W, AESU_FUNC_EXTRACT};
        issue(w, 32'h0, 1'b1, 1'b0, 1'b1);
        chk("reserved", 32'h1, 32'(eri));
        chk("valid", 32'h0, 32'(rv));
        issue(w, 32'h0, 1'b1, 1'b1, 1'b0);
        chk("disabled", 32'h1, 32'(edd));
        chk("valid", 32'h0, 32'(rv));
        w[13] = 1'b1;
        issue(w, 32'h0, 1'b0, 1'b1, 1'b1);
        chk("valid", 32'h0, 32'(rv));
    endtask
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        sc_words();
        sc_half();
        sc_ctrl();
        sc_reset();
        sc_exc();
        close_out();
    end
endmodule // testbench
`default_nettype wire
